// File: test/ddo_far.sv
/*
  far side model: serial link controller and left neighbour's blank-out.
  assumes one bench process calls its tasks, right after rising edges.
*/
`timescale 1ns/1ns
module ddo_far (
  input wire clk_i,
  output logic [3:0] digit_code_o,
  output logic digit_point_o,
  output logic digit_valid_o,
  output logic link_ok_o,
  output logic chain_o
);
  // idle: link good, no digit, neighbour not blanking
  initial begin
    digit_code_o = 4'h5;
    digit_point_o = 1'b0;
    digit_valid_o = 1'b0;
    link_ok_o = 1'b1;
    chain_o = 1'b0;
  end
  // one code per pulse; lines then show the inverse so stale data never looks held
  task automatic send(input logic [3:0] c, input logic p);
    @(posedge clk_i);
    digit_code_o <= c;
    digit_point_o <= p;
    digit_valid_o <= 1'b1;
    @(posedge clk_i);
    digit_code_o <= ~c;
    digit_point_o <= ~p;
    digit_valid_o <= 1'b0;
  endtask
  // reception good or failed, as a level
  task automatic set_link(input logic v);
    @(posedge clk_i);
    link_ok_o <= v;
  endtask
  // neighbour's blank-out feeds our chain input
  task automatic set_chain(input logic v);
    @(posedge clk_i);
    chain_o <= v;
  endtask
endmodule

// File: test/ddo_sva.sv
/*
  port checker for the digit option control block.
  assumes decimal builds that light red at least from the external red line,
  bound below to every ddo_digit_ctrl.
*/
`timescale 1ns/1ns
module ddo_sva (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_ack_o,
  input wire [31:0] wb_dat_o,
  input wire [3:0] digit_code_i,
  input wire digit_valid_i,
  input wire link_ok_i,
  input wire ext_connected_i,
  input wire ext_red_i,
  input wire [6:0] seg_o,
  input wire point_o,
  input wire red_o,
  input wire green_o,
  input wire blank_out_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  property p_ack_next;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("no ack after request");
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_dat_idle;
    !wb_ack_o |-> wb_dat_o == 32'h0;
  endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
  property p_code_blank;
    digit_valid_i && link_ok_i && digit_code_i == 4'hf ##1 link_ok_i |=> seg_o == 7'h00;
  endproperty
  a_code_blank: assert property (p_code_blank) else $error("code f not blank");
  property p_link_err;
    !link_ok_i |=> !point_o && (seg_o == 7'h40 || seg_o == 7'h00);
  endproperty
  a_link_err: assert property (p_link_err) else $error("failed link not minus");
  property p_ext_red;
    ext_connected_i && ext_red_i |=> red_o;
  endproperty
  a_ext_red: assert property (p_ext_red) else $error("external red ignored");
  property p_dark;
    !red_o && !green_o |-> seg_o == 7'h00 && !point_o;
  endproperty
  a_dark: assert property (p_dark) else $error("dark unit lit");
  property p_supp;
    blank_out_o |-> seg_o == 7'h00;
  endproperty
  a_supp: assert property (p_supp) else $error("blank-out with digit lit");
endmodule
bind ddo_digit_ctrl ddo_sva i_ddo_sva (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .wb_dat_o,
  .digit_code_i, .digit_valid_i, .link_ok_i, .ext_connected_i, .ext_red_i, .seg_o, .point_o, .red_o,
  .green_o, .blank_out_o);

// File: test/tb.sv
/*
  self-checking bench for ddo_digit_ctrl with short flash counts.
  assumes ddo_far drives the link side and ddo_sva is bound in.
*/
`timescale 1ns/1ns
`include "ddo_map.vh"
module tb;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0, rd, rd2;
  logic [3:0] sel = 4'hf;
  logic ext_c = 0, ext_p = 0, ext_r = 0, ext_g = 0;
  wire [31:0] dat_o;
  wire [6:0] seg;
  wire [3:0] code;
  wire ack, pt, red, grn, bo, irq, dp, dv, lk, ch;
  wire [31:0] dat2;
  wire [6:0] seg2;
  wire pt2, red2, grn2;
  int n_fail = 0, checked = 0;
  // 125 mhz
  always #4 clk_i = ~clk_i;
  ddo_far i_ddo_far (.clk_i(clk_i), .digit_code_o(code), .digit_point_o(dp), .digit_valid_o(dv),
    .link_ok_o(lk), .chain_o(ch));
  // short flash so the off phase is reached quickly
  ddo_digit_ctrl #(.TICK_CYCLES(4), .FLASH_TICKS(3)) i_ddo_digit_ctrl (.clk_i(clk_i), .rst_i(rst_i),
    .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .digit_code_i(code), .digit_point_i(dp), .digit_valid_i(dv),
    .link_ok_i(lk), .ext_connected_i(ext_c), .ext_point_i(ext_p), .ext_red_i(ext_r), .ext_green_i(ext_g),
    .blank_chain_in_i(ch), .seg_o(seg), .point_o(pt), .red_o(red), .green_o(grn), .blank_out_o(bo),
    .irq_o(irq));
  // switch build, single colour red, on the same bus and link
  ddo_digit_ctrl #(.SWITCH_MODEL(1), .THREE_COLOUR(0), .TICK_CYCLES(4), .FLASH_TICKS(3)) i_ddo_digit_ctrl_sw (
    .clk_i(clk_i), .rst_i(rst_i),
    .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_dat_o(dat2), .wb_ack_o(), .digit_code_i(code), .digit_point_i(dp), .digit_valid_i(dv),
    .link_ok_i(lk), .ext_connected_i(ext_c), .ext_point_i(ext_p), .ext_red_i(ext_r), .ext_green_i(ext_g),
    .blank_chain_in_i(ch), .seg_o(seg2), .point_o(pt2), .red_o(red2), .green_o(grn2), .blank_out_o(),
    .irq_o());
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // classic single cycle; held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    rd = dat_o;
    rd2 = dat2;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  // outputs are registered twice behind a digit, so three edges cover every path
  task settle;
    repeat (3) @(posedge clk_i);
    #1;
  endtask
  task conclude;
    if (n_fail == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task t_regs;
    wb(0, `DDO_ADR_OPTION, 0);
    chk(rd, 32'h1f);
    chk(rd2, 32'h00);
    wb(1, `DDO_ADR_OPTION, 32'h7f);
    wb(0, `DDO_ADR_OPTION, 0);
    chk(rd, 32'h1f);
    chk(rd2, 32'h07);
    sel <= 4'he;
    wb(1, `DDO_ADR_OPTION, 32'h00);
    sel <= 4'hf;
    wb(0, `DDO_ADR_OPTION, 0);
    chk(rd, 32'h1f);
    wb(0, 8'h14, 0);
    chk(rd, 32'h0);
    wb(0, `DDO_ADR_STATE, 0);
    chk(rd & 32'hf, 32'hf);
  endtask
  task t_irq;
    wb(1, `DDO_ADR_CLEAR, 32'hf);
    wb(1, `DDO_ADR_ENABLE, 32'h4);
    settle;
    chk(irq, 0);
    i_ddo_far.send(4'h1, 0);
    settle;
    chk(irq, 1);
    wb(0, `DDO_ADR_STATUS, 0);
    chk(rd & 32'h4, 32'h4);
    wb(1, `DDO_ADR_CLEAR, 32'h4);
    settle;
    chk(irq, 0);
    wb(1, `DDO_ADR_ENABLE, 32'h0);
    i_ddo_far.send(4'h2, 0);
    settle;
    chk(irq, 0);
  endtask
  task t_code;
    i_ddo_far.send(4'hf, 0);
    settle;
    chk(seg, 7'h00);
    i_ddo_far.send(4'h1, 0);
    settle;
    chk(seg, 7'h06);
    chk(pt, 1);
  endtask
  // every colour option pair with the external connector absent, then the external colour and point lines
  task t_colour;
    for (int i = 0; i < 4; i++) begin
      wb(1, `DDO_ADR_OPTION, {27'h0, i[1:0], 3'b100});
      settle;
      chk(red, i[0]);
      chk(grn, i[1]);
      chk(seg, (i == 0) ? 7'h00 : 7'h06);
      chk(red2, 1);
      chk(grn2, 0);
      chk(seg2, 7'h06);
    end
    wb(1, `DDO_ADR_OPTION, 32'h04);
    ext_c <= 1'b1;
    ext_r <= 1'b1;
    ext_p <= 1'b1;
    settle;
    chk(red, 1);
    chk(grn, 0);
    chk(pt, 1);
    @(posedge clk_i);
    ext_r <= 1'b0;
    ext_g <= 1'b1;
    ext_p <= 1'b0;
    settle;
    chk(red, 0);
    chk(grn, 1);
    chk(pt, 0);
    wb(1, `DDO_ADR_OPTION, 32'h1d);
    settle;
    chk(red, 1);
    chk(pt, 1);
    chk(pt2, 1);
    @(posedge clk_i);
    ext_c <= 1'b0;
    ext_g <= 1'b0;
  endtask
  task t_link;
    i_ddo_far.set_link(0);
    settle;
    chk(seg, 7'h40);
    chk(pt, 0);
    repeat (12) @(posedge clk_i);
    #1;
    chk(seg, 7'h00);
    i_ddo_far.set_link(1);
    settle;
    chk(seg, 7'h06);
  endtask
  task t_supp;
    i_ddo_far.send(4'h0, 0);
    wb(1, `DDO_ADR_OPTION, 32'h1e);
    settle;
    chk(seg, 7'h00);
    chk(bo, 1);
    wb(1, `DDO_ADR_OPTION, 32'h1a);
    settle;
    chk(seg, 7'h3f);
    chk(bo, 0);
    wb(1, `DDO_ADR_OPTION, 32'h1c);
    i_ddo_far.set_chain(1);
    settle;
    chk(bo, 1);
    i_ddo_far.set_chain(0);
    settle;
    chk(seg, 7'h3f);
    chk(bo, 0);
  endtask
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs;
    t_irq;
    t_code;
    t_colour;
    t_link;
    t_supp;
    conclude;
  end
  // the sequence needs well under a thousand cycles
  initial begin
    #200000;
    n_fail++;
    conclude;
  end
endmodule

// File: verilog/ddo_digit_ctrl.v
/*
  option control and blanking for one cascadable numeric digit unit:
  option settings, zero suppression chain, colour select, link error
  flashing, a classic wishbone register slave and an event interrupt.
  assumes all inputs are synchronous to clk_i; the serial receiver outside
  delivers a digit code with a one-cycle valid and a link good level.
*/
// Design decisions made here: the Wishbone register port and the register addresses.
`timescale 1ns/1ns
`include "ddo_map.vh"

module ddo_digit_ctrl #(
  parameter SWITCH_MODEL = 0,
  parameter THREE_COLOUR = 1,
  parameter FIXED_GREEN = 0,
  parameter HEX_MODEL = 0,
  parameter TICK_CYCLES = `DDO_TICK_CYCLES,
  parameter FLASH_TICKS = `DDO_FLASH_MS
) (
  input wire clk_i,
  input wire rst_i,
  input wire [7:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire [3:0] wb_sel_i,
  input wire wb_we_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire [3:0] digit_code_i,
  input wire digit_point_i,
  input wire digit_valid_i,
  input wire link_ok_i,
  input wire ext_connected_i,
  input wire ext_point_i,
  input wire ext_red_i,
  input wire ext_green_i,
  input wire blank_chain_in_i,
  output reg [6:0] seg_o,
  output reg point_o,
  output reg red_o,
  output reg green_o,
  output reg blank_out_o,
  output reg irq_o
);

  // option reset depends on the build: jumpers shorted or switches off
  localparam [`DDO_OPT_W-1:0] OPT_RST = (SWITCH_MODEL != 0) ?
    `DDO_OPT_SWITCH_RST : `DDO_OPT_JUMPER_RST;

  // colour bits exist only on three-colour builds
  localparam [`DDO_OPT_W-1:0] OPT_MASK = (THREE_COLOUR != 0) ?
    5'h1f : 5'h07;

  // brightness trim is a fixed strap, readable, never written
  localparam [`DDO_TRIM_W-1:0] TRIM = `DDO_TRIM_RST;

  // divider end points, cut to the counter widths on purpose
  localparam integer TICK_LAST_N = TICK_CYCLES - 1;
  localparam integer FLASH_LAST_N = FLASH_TICKS - 1;
  localparam [16:0] TICK_LAST = TICK_LAST_N[16:0];
  localparam [9:0] FLASH_LAST = FLASH_LAST_N[9:0];

  // which register a bus address selects
  localparam SEL_NONE = 3'h0;
  localparam SEL_OPTION = 3'h1;
  localparam SEL_STATUS = 3'h2;
  localparam SEL_CLEAR = 3'h3;
  localparam SEL_ENABLE = 3'h4;
  localparam SEL_STATE = 3'h5;

  // address decode, used for both the read mux and the write strobes
  // unmapped addresses fall to none: still acked, read zero, writes dropped
  function [2:0] reg_sel;
    input [7:0] adr;
    begin
      case (adr)
        `DDO_ADR_OPTION: reg_sel = SEL_OPTION;
        `DDO_ADR_STATUS: reg_sel = SEL_STATUS;
        `DDO_ADR_CLEAR: reg_sel = SEL_CLEAR;
        `DDO_ADR_ENABLE: reg_sel = SEL_ENABLE;
        `DDO_ADR_STATE: reg_sel = SEL_STATE;
        default: reg_sel = SEL_NONE;
      endcase
    end
  endfunction

  reg [`DDO_OPT_W-1:0] option;
  reg [`DDO_EV_W-1:0] status;
  reg [`DDO_EV_W-1:0] enable;
  reg [3:0] digit;
  reg rx_point;
  reg link_ok_d;
  reg [16:0] tick_cnt;
  reg [9:0] flash_cnt;
  reg flash_on;

  wire [2:0] sel;
  wire bus_req;
  wire wr_lane0;
  wire [6:0] dec_seg;

  reg next_red;
  reg next_green;
  reg next_point;
  reg [6:0] next_seg;
  reg next_blank_out;
  reg [`DDO_EV_W-1:0] events;
  reg [`DDO_EV_W-1:0] clear;
  reg [`DDO_EV_W-1:0] next_status;
  reg [31:0] next_rdata;

  wire chain_in;
  wire suppress;

  assign sel = reg_sel(wb_adr_i);
  // a request is served once; the master drops stb after ack
  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // every field sits in byte lane 0, so only that lane writes
  assign wr_lane0 = bus_req & wb_we_i & wb_sel_i[0];

  ddo_seg_decode #(
    .HEX_MODEL(HEX_MODEL)
  ) u_decode (
    .code_i(digit),
    .seg_o(dec_seg)
  );

  // bus handshake: ack one cycle after the request, low the next
  // a write lands at the edge that raises ack; the master holds the request
  // until it samples ack, so it never sees a half-written register
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= bus_req ? next_rdata : 32'h0000_0000;
    end
  end

  // read mux; clear is write only and unmapped words read zero
  // reads have no side effect, so a repeated read is harmless
  always @* begin
    next_rdata = 32'h0000_0000;
    case (sel)
      SEL_OPTION: begin
        next_rdata[`DDO_OPT_W-1:0] = option;
        next_rdata[`DDO_OPT_TRIM_LO+1:`DDO_OPT_TRIM_LO] = TRIM;
      end
      SEL_STATUS: next_rdata[`DDO_EV_W-1:0] = status;
      SEL_ENABLE: next_rdata[`DDO_EV_W-1:0] = enable;
      SEL_STATE: begin
        next_rdata[`DDO_ST_CODE_LO+3:`DDO_ST_CODE_LO] = digit;
        next_rdata[`DDO_ST_LINK] = link_ok_d;
        next_rdata[`DDO_ST_BLANK_OUT] = blank_out_o;
        next_rdata[`DDO_ST_RED] = red_o;
        next_rdata[`DDO_ST_GREEN] = green_o;
      end
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  // option register: switch on and jumper shorted are the same set bit
  // a changed blank-in or pass bit shows on the outputs one cycle later
  always @(posedge clk_i) begin
    if (rst_i) begin
      option <= OPT_RST & OPT_MASK;
    end else if (wr_lane0 && sel == SEL_OPTION) begin
      option <= wb_dat_i[`DDO_OPT_W-1:0] & OPT_MASK;
    end
  end

  // interrupt enable register
  // enable bits gate only the interrupt; status logs every event anyway
  always @(posedge clk_i) begin
    if (rst_i) begin
      enable <= {`DDO_EV_W{1'b0}};
    end else if (wr_lane0 && sel == SEL_ENABLE) begin
      enable <= wb_dat_i[`DDO_EV_W-1:0];
    end
  end

  // received digit, taken only while the link is good
  // a code sent during a dropout is lost, not queued; the controller repeats
  always @(posedge clk_i) begin
    if (rst_i) begin
      digit <= `DDO_CODE_BLANK;
      rx_point <= 1'b0;
    end else if (digit_valid_i && link_ok_i) begin
      digit <= digit_code_i;
      rx_point <= digit_point_i;
    end
  end

  // link level history for the fail and recover events
  // resets high so a unit that starts with the link down logs a failure
  always @(posedge clk_i) begin
    if (rst_i) begin
      link_ok_d <= 1'b1;
    end else begin
      link_ok_d <= link_ok_i;
    end
  end

  // millisecond enable pulse from the clock divider
  // held at zero while the link is good so each failure starts a full phase
  always @(posedge clk_i) begin
    if (rst_i || link_ok_i) begin
      tick_cnt <= 17'h00000;
    end else if (tick_cnt == TICK_LAST) begin
      tick_cnt <= 17'h00000;
    end else begin
      tick_cnt <= tick_cnt + 17'h00001;
    end
  end

  // flash phase; restarts lit so the minus shows at once on a failure
  // a cut shorter than one half period shows a steady minus, no flash
  always @(posedge clk_i) begin
    if (rst_i || link_ok_i) begin
      flash_cnt <= 10'h000;
      flash_on <= 1'b1;
    end else if (tick_cnt == TICK_LAST) begin
      if (flash_cnt == FLASH_LAST) begin
        flash_cnt <= 10'h000;
        flash_on <= ~flash_on;
      end else begin
        flash_cnt <= flash_cnt + 10'h001;
      end
    end
  end

  // chain input comes from the own option or from the left neighbour
  // blank-out is registered, so the chain ripples one cycle per unit
  assign chain_in = option[`DDO_OPT_BLANK_IN] | blank_chain_in_i;
  // pass open on the last unit keeps its zero visible
  assign suppress = chain_in & (digit == 4'h0) &
    option[`DDO_OPT_PASS] & link_ok_i;

  // colour select: set option wins, external input acts only when open
  // single-colour builds ignore both the colour options and colour lines
  always @* begin
    if (THREE_COLOUR != 0) begin
      next_red = option[`DDO_OPT_RED] |
        (ext_connected_i & ext_red_i);
      next_green = option[`DDO_OPT_GREEN] |
        (ext_connected_i & ext_green_i);
    end else begin
      next_red = (FIXED_GREEN == 0);
      next_green = (FIXED_GREEN != 0);
    end
  end

  // segments and point; a dark colour leaves everything off
  // the error display ignores suppression, so a failed unit passes no
  // blank-out on; a dark unit still passes blank-out to its neighbour
  always @* begin
    next_seg = `DDO_SEG_OFF;
    next_point = 1'b0;
    next_blank_out = 1'b0;
    if (!link_ok_i) begin
      next_seg = flash_on ? `DDO_SEG_MINUS : `DDO_SEG_OFF;
    end else if (suppress) begin
      next_blank_out = 1'b1;
      next_point = option[`DDO_OPT_POINT];
    end else begin
      next_seg = dec_seg;
      next_point = option[`DDO_OPT_POINT] |
        (ext_connected_i & ext_point_i) | rx_point;
    end
    // no colour selected and nothing connected: dark
    if (!(next_red | next_green)) begin
      next_seg = `DDO_SEG_OFF;
      next_point = 1'b0;
    end
  end

  // display outputs, all registered
  // one register stage for all of them, so they always change together
  always @(posedge clk_i) begin
    if (rst_i) begin
      seg_o <= `DDO_SEG_OFF;
      point_o <= 1'b0;
      red_o <= 1'b0;
      green_o <= 1'b0;
      blank_out_o <= 1'b0;
    end else begin
      seg_o <= next_seg;
      point_o <= next_point;
      red_o <= next_red;
      green_o <= next_green;
      blank_out_o <= next_blank_out;
    end
  end

  // events of this cycle and the clear strobe of a bus write
  // link events come from the level history, so a one-cycle dropout
  // still logs both its failure and its recovery
  always @* begin
    events = {`DDO_EV_W{1'b0}};
    events[`DDO_EV_LINK_FAIL] = link_ok_d & ~link_ok_i;
    events[`DDO_EV_LINK_BACK] = ~link_ok_d & link_ok_i;
    events[`DDO_EV_DIGIT] = digit_valid_i & link_ok_i;
    events[`DDO_EV_BLANK] = next_blank_out & ~blank_out_o;
    clear = {`DDO_EV_W{1'b0}};
    if (wr_lane0 && sel == SEL_CLEAR) begin
      clear = wb_dat_i[`DDO_EV_W-1:0];
    end
    // a new event beats a clear in the same cycle
    next_status = (status & ~clear) | events;
  end

  // sticky status and the level interrupt
  // irq follows next_status so it rises with the status bit, not a cycle
  // later, and drops at the same edge that the clear lands
  always @(posedge clk_i) begin
    if (rst_i) begin
      status <= {`DDO_EV_W{1'b0}};
      irq_o <= 1'b0;
    end else begin
      status <= next_status;
      irq_o <= |(next_status & enable);
    end
  end

endmodule

// File: verilog/ddo_map.vh
/*
  register offsets, field positions, reset values, display codes and timing
  figures shared by the digit option control design files.
  assumes byte addressing on a 32-bit classic wishbone bus, 125 mhz clock.
*/
`ifndef DDO_MAP_VH
`define DDO_MAP_VH

// register byte offsets, one aligned word each
`define DDO_ADR_OPTION 8'h00
`define DDO_ADR_STATUS 8'h04
`define DDO_ADR_CLEAR 8'h08
`define DDO_ADR_ENABLE 8'h0c
`define DDO_ADR_STATE 8'h10

// option register fields
`define DDO_OPT_POINT 0
`define DDO_OPT_BLANK_IN 1
`define DDO_OPT_PASS 2
`define DDO_OPT_RED 3
`define DDO_OPT_GREEN 4
`define DDO_OPT_W 5
`define DDO_OPT_TRIM_LO 5
`define DDO_TRIM_W 2

// option reset values per build
`define DDO_OPT_JUMPER_RST 5'h1f
`define DDO_OPT_SWITCH_RST 5'h00
`define DDO_TRIM_RST 2'h0

// event bits of status, clear and enable
`define DDO_EV_LINK_FAIL 0
`define DDO_EV_LINK_BACK 1
`define DDO_EV_DIGIT 2
`define DDO_EV_BLANK 3
`define DDO_EV_W 4

// state register fields
`define DDO_ST_CODE_LO 0
`define DDO_ST_LINK 4
`define DDO_ST_BLANK_OUT 5
`define DDO_ST_RED 6
`define DDO_ST_GREEN 7

// digit codes and segment patterns, segment order g f e d c b a
`define DDO_CODE_MINUS 4'ha
`define DDO_CODE_BLANK 4'hf
`define DDO_SEG_MINUS 7'h40
`define DDO_SEG_OFF 7'h00

// timing
`define DDO_CLK_NS 8
`define DDO_TICK_NS 1000000
`define DDO_TICK_CYCLES (`DDO_TICK_NS / `DDO_CLK_NS)
`define DDO_FLASH_MS 500

`endif

// File: verilog/ddo_seg_decode.v
/*
  combinational digit code to seven segment decoder.
  assumes the caller registers the result; code f always decodes blank.
*/
`timescale 1ns/1ns
`include "ddo_map.vh"

module ddo_seg_decode #(
  parameter HEX_MODEL = 0
) (
  input wire [3:0] code_i,
  output reg [6:0] seg_o
);

  // decimal builds show a minus for code a and blank b to e
  always @* begin
    case (code_i)
      4'h0: seg_o = 7'h3f;
      4'h1: seg_o = 7'h06;
      4'h2: seg_o = 7'h5b;
      4'h3: seg_o = 7'h4f;
      4'h4: seg_o = 7'h66;
      4'h5: seg_o = 7'h6d;
      4'h6: seg_o = 7'h7d;
      4'h7: seg_o = 7'h07;
      4'h8: seg_o = 7'h7f;
      4'h9: seg_o = 7'h6f;
      4'ha: seg_o = (HEX_MODEL != 0) ? 7'h77 : `DDO_SEG_MINUS;
      4'hb: seg_o = (HEX_MODEL != 0) ? 7'h7c : `DDO_SEG_OFF;
      4'hc: seg_o = (HEX_MODEL != 0) ? 7'h39 : `DDO_SEG_OFF;
      4'hd: seg_o = (HEX_MODEL != 0) ? 7'h5e : `DDO_SEG_OFF;
      4'he: seg_o = (HEX_MODEL != 0) ? 7'h79 : `DDO_SEG_OFF;
      `DDO_CODE_BLANK: seg_o = `DDO_SEG_OFF;
      default: seg_o = `DDO_SEG_OFF;
    endcase
  end

endmodule
